// file: verilog/pwr_state_defines.svh
/*
  power-on state and i/o port block: offsets, field positions, reset values
  and timing counts as macros. assumes a 50 MHz ref_clk.
*/
`ifndef PWR_STATE_DEFINES_SVH
`define PWR_STATE_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets (word index on the plain register port)
// ----------------------------------------------------------------------
`define OFS_DATA_A      4'h0
`define OFS_DATA_B      4'h1
`define OFS_FUNC        4'h2
`define OFS_PORT_DIR    4'h3
`define OFS_PORT_OUT    4'h4
`define OFS_PORT_IN     4'h5
`define OFS_STATUS      4'h6

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define FUNC_GND_ADJ_BIT 0
`define ZERO_CODE       16'h0000
`define DATA_RST        16'h0000
`define PORT_RST        2'h0

// ----------------------------------------------------------------------
// timing: strap sampling waits for supplies to settle
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS   20
`define SETTLE_TIME_NS  1000
`define SETTLE_CYCLES   ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: verilog/pwr_state_pkg.sv
/*
  types for the power-on state block. assumes the defines header sits beside.
*/
package pwr_state_pkg;
  // power-up output state chosen from straps
  typedef enum logic [1:0] {
    out_clamped,
    out_zero_code,
    out_driving
  } out_state_t;

  // strap levels sampled at power-on
  typedef struct packed {
    logic coding_sel;
    logic zero_n;
    logic load_n;
  } strap_t;
endpackage : pwr_state_pkg

// file: verilog/pin_sync.sv
/*
  three-stage synchroniser for a pin bus; a change counts once stages two
  and three agree. assumes ref_clk domain and async active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk, // clock
  input  wire logic         rstn,    // async reset, active low
  input  wire logic [W-1:0] pin_in,  // raw pins
  output var  logic [W-1:0] pin_out  // filtered level
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  // --------------------------------------------------------------------
  // accept a level only after two clean samples agree
  // --------------------------------------------------------------------
  always_comb
  begin
    out_d = out_q;
    for (int i = 0; i < W; i++)
    begin
      if (s2_q[i] == s3_q[i])
        out_d[i] = s3_q[i];
    end
  end

  // first stage is read only by the second
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end
    else
    begin
      s1_q  <= pin_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign pin_out = out_q;
endmodule : pin_sync
`default_nettype wire

// file: verilog/pwr_state_io.sv
/*
  power-on output state, 2-bit general port and ground offset enable.
  assumes a host reaches registers over a plain strobe port on ref_clk and
  that the straps are stable by the end of the settle time after rstn.
*/
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "pwr_state_defines.svh"

module pwr_state_io
  import pwr_state_pkg::*;
(
  input  wire logic        ref_clk,            // 50 MHz clock
  input  wire logic        rstn,               // async reset, active low
  input  wire logic [3:0]  addr,               // register index
  input  wire logic [15:0] wdata,              // write data
  input  wire logic        wr,                 // write strobe
  input  wire logic        rd,                 // read strobe
  output var  logic [15:0] rdata,              // read data, next cycle
  input  wire logic        async_zero_input,   // zero strap, active low
  input  wire logic        load_update_strobe, // load strobe, active low
  input  wire logic        coding_select_pin,  // 1 offset binary, 0 twos comp
  input  wire logic        port_pin_zero_in,   // port pin 0 level
  input  wire logic        port_pin_one_in,    // port pin 1 level
  output var  logic        port_pin_zero_out,  // port pin 0 drive
  output var  logic        port_pin_one_out,   // port pin 1 drive
  output var  logic        port_pin_zero_oe_n, // low while driving pin 0
  output var  logic        port_pin_one_oe_n,  // low while driving pin 1
  output var  logic [15:0] dac_code_a,         // channel a output code
  output var  logic [15:0] dac_code_b,         // channel b output code
  output var  logic        out_clamp,          // outputs held at local ground
  output var  logic        offset_binary,      // coding in force
  output var  logic        gnd_adj_en          // ground offset correction on
);
  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  logic [4:0] pins_s;
  pin_sync #(.W(5)) u_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .pin_in  ({coding_select_pin, async_zero_input, load_update_strobe,
               port_pin_one_in, port_pin_zero_in}),
    .pin_out (pins_s)
  );

  strap_t live_strap;
  assign live_strap = '{coding_sel: pins_s[4], zero_n: pins_s[3], load_n: pins_s[2]};

  // --------------------------------------------------------------------
  // state registers
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    ph_settle,
    ph_run
  } phase_t;

  phase_t      phase_q, phase_d;
  logic [7:0]  settle_q, settle_d;
  out_state_t  ost_q, ost_d;
  logic        coding_q, coding_d;
  logic [15:0] data_a_q, data_a_d, data_b_q, data_b_d;
  logic [15:0] act_a_q, act_a_d, act_b_q, act_b_d;
  logic        gnd_q, gnd_d;
  logic [1:0]  dir_q, dir_d, pout_q, pout_d;
  logic [15:0] rdata_q, rdata_d;
  logic        clamp_q, clamp_d;

  // --------------------------------------------------------------------
  // power-up sequencing, data and port registers, read mux
  // --------------------------------------------------------------------
  always_comb
  begin
    phase_d  = phase_q;
    settle_d = settle_q;
    ost_d    = ost_q;
    coding_d = coding_q;
    data_a_d = data_a_q;
    data_b_d = data_b_q;
    act_a_d  = act_a_q;
    act_b_d  = act_b_q;
    gnd_d    = gnd_q;
    dir_d    = dir_q;
    pout_d   = pout_q;
    clamp_d  = clamp_q;
    rdata_d  = 16'h0000;

    unique case (phase_q)
      // supplies settling: outputs clamped, writes ignored
      ph_settle:
      begin
        clamp_d = 1'b1;
        if (settle_q == 8'((`SETTLE_CYCLES) - 1))
        begin
          phase_d  = ph_run;
          coding_d = live_strap.coding_sel;
          // strap decode: any low strobe drives zero code
          if (!live_strap.zero_n || !live_strap.load_n)
          begin
            ost_d    = out_zero_code;
            data_a_d = `ZERO_CODE;
            data_b_d = `ZERO_CODE;
            act_a_d  = `ZERO_CODE;
            act_b_d  = `ZERO_CODE;
            clamp_d  = 1'b0;
          end
          else
          begin
            ost_d = out_clamped;
          end
        end
        else
        begin
          settle_d = settle_q + 8'h01;
        end
      end
      ph_run:
      begin
        if (wr)
        begin
          unique case (addr)
            `OFS_DATA_A:
            begin
              data_a_d = wdata;
              act_a_d  = wdata;
              clamp_d  = 1'b0;
              ost_d    = out_driving;
            end
            `OFS_DATA_B:
            begin
              data_b_d = wdata;
              act_b_d  = wdata;
              clamp_d  = 1'b0;
              ost_d    = out_driving;
            end
            `OFS_FUNC:     gnd_d  = wdata[`FUNC_GND_ADJ_BIT];
            `OFS_PORT_DIR: dir_d  = wdata[1:0];
            `OFS_PORT_OUT: pout_d = wdata[1:0];
            default: ;
          endcase
        end
      end
      default: phase_d = ph_settle;
    endcase

    // reads answer in the next cycle; unmapped reads give zero
    if (rd)
    begin
      unique case (addr)
        `OFS_DATA_A:   rdata_d = data_a_q;
        `OFS_DATA_B:   rdata_d = data_b_q;
        `OFS_FUNC:     rdata_d = {15'h0000, gnd_q};
        `OFS_PORT_DIR: rdata_d = {14'h0000, dir_q};
        `OFS_PORT_OUT: rdata_d = {14'h0000, pout_q};
        // input pins read live level, output pins read their drive
        `OFS_PORT_IN:  rdata_d = {14'h0000, (dir_q & pout_q) | (~dir_q & pins_s[1:0])};
        `OFS_STATUS:   rdata_d = {11'h000, coding_q, clamp_q, ost_q, phase_q == ph_run};
        default:       rdata_d = 16'h0000;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // register stage
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase_q  <= ph_settle;
      settle_q <= 8'h00;
      ost_q    <= out_clamped;
      coding_q <= 1'b0;
      data_a_q <= `DATA_RST;
      data_b_q <= `DATA_RST;
      act_a_q  <= `DATA_RST;
      act_b_q  <= `DATA_RST;
      gnd_q    <= 1'b0;
      dir_q    <= `PORT_RST;
      pout_q   <= `PORT_RST;
      rdata_q  <= 16'h0000;
      clamp_q  <= 1'b1; // clamped from the very start
    end
    else
    begin
      phase_q  <= phase_d;
      settle_q <= settle_d;
      ost_q    <= ost_d;
      coding_q <= coding_d;
      data_a_q <= data_a_d;
      data_b_q <= data_b_d;
      act_a_q  <= act_a_d;
      act_b_q  <= act_b_d;
      gnd_q    <= gnd_d;
      dir_q    <= dir_d;
      pout_q   <= pout_d;
      rdata_q  <= rdata_d;
      clamp_q  <= clamp_d;
    end
  end

  // every output is a flip-flop, except the two oe_n enables, which are inverted flip-flops
  assign rdata              = rdata_q;
  assign dac_code_a         = act_a_q;
  assign dac_code_b         = act_b_q;
  assign out_clamp          = clamp_q;
  assign offset_binary      = coding_q;
  assign gnd_adj_en         = gnd_q;
  assign port_pin_zero_out  = pout_q[0];
  assign port_pin_one_out   = pout_q[1];
  assign port_pin_zero_oe_n = ~dir_q[0];
  assign port_pin_one_oe_n  = ~dir_q[1];
endmodule : pwr_state_io
`default_nettype wire

// file: tb/pwr_state_checker.sv
/*
  port assertions for the power-on state block.
  assumes a bind onto pwr_state_io, one clock, async active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pwr_state_defines.svh"
module pwr_state_checker (
  input wire logic        ref_clk,            // clock
  input wire logic        rstn,               // reset
  input wire logic [3:0]  addr,               // index
  input wire logic [15:0] wdata,              // write data
  input wire logic        wr,                 // write
  input wire logic        rd,                 // read
  input wire logic [15:0] rdata,              // read data
  input wire logic        port_pin_zero_out,  // drive 0
  input wire logic        port_pin_one_out,   // drive 1
  input wire logic        port_pin_zero_oe_n, // enable 0
  input wire logic        port_pin_one_oe_n,  // enable 1
  input wire logic [15:0] dac_code_a,         // code a
  input wire logic [15:0] dac_code_b,         // code b
  input wire logic        out_clamp,          // clamp
  input wire logic        offset_binary,      // coding
  input wire logic        gnd_adj_en          // ground adjust
);
  logic [6:0]  cnt_q, cnt_d;
  logic [15:0] wd_q;
  logic        run, settle;
  // cycles since release; writes count once the settle count has run out
  always_comb cnt_d = (cnt_q == 7'h3c) ? cnt_q : cnt_q + 7'h01;
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn) {cnt_q, wd_q} <= 23'h000000;
    else {cnt_q, wd_q} <= {cnt_d, wdata};
  assign run    = (cnt_q >= 7'(`SETTLE_CYCLES));
  assign settle = !run;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_code_a_load: assert property (wr && addr == 4'h0 && run |=> dac_code_a == $past(wdata))
    else $error("code a missed write");
  a_code_b_load: assert property (wr && addr == 4'h1 && run |=> dac_code_b == $past(wdata))
    else $error("code b missed write");
  a_clamp_release: assert property ($fell(out_clamp) |-> ($past(wr) && $past(addr) <= 4'h1)
    || (dac_code_a == 16'h0000 && dac_code_b == 16'h0000))
    else $error("clamp dropped without cause");
  a_port_drive: assert property (wr && addr == 4'h4 && run |=>
    {port_pin_one_out, port_pin_zero_out} == wd_q[1:0])
    else $error("port drive wrong");
  a_port_dir: assert property (wr && addr == 4'h3 && run |=>
    {port_pin_one_oe_n, port_pin_zero_oe_n} == {~wd_q[1:0]})
    else $error("port direction wrong");
  a_gnd_adj_set: assert property (wr && addr == 4'h2 && run |=> gnd_adj_en == wd_q[0])
    else $error("ground adjust wrong");
  a_settle_ignore: assert property (wr && settle |=> $stable(gnd_adj_en)
    && $stable(port_pin_zero_oe_n))
    else $error("write taken while settling");
  a_status_view: assert property (rd && addr == 4'h6 && run |=>
    rdata[4:3] == {offset_binary, out_clamp})
    else $error("status wrong");
endmodule : pwr_state_checker
`default_nettype wire

// file: tb/port_pins_model.sv
/*
  the two port pins as the board sees them.
  assumes oe_n low means the block drives; else a switch sets the level.
*/
`timescale 1ns/10ps
`default_nettype none
module port_pins_model (
  input  wire logic       oe0_n, // pin 0 enable
  input  wire logic       oe1_n, // pin 1 enable
  input  wire logic       d0,    // pin 0 drive
  input  wire logic       d1,    // pin 1 drive
  input  wire logic [1:0] ext,   // switch levels
  output var  logic       p0,    // pin 0 level
  output var  logic       p1     // pin 1 level
);
  // each pin owned by one side at a time; contention is not modelled
  assign p0 = oe0_n ? ext[0] : d0;
  assign p1 = oe1_n ? ext[1] : d1;
endmodule : port_pins_model
`default_nettype wire

// file: tb/pwr_state_io_tb_top.sv
/*
  bench: strap sweep through resets, then random port traffic.
  assumes the pin model beside the design and a 50 MHz ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module pwr_state_io_tb_top import pwr_state_pkg::*;;
  logic        ref_clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        async_zero_input = 1'b1, load_update_strobe = 1'b1, coding_select_pin = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, dac_code_a, dac_code_b, v;
  logic [1:0]  ext = 2'h0;
  logic        port_pin_zero_in, port_pin_one_in, port_pin_zero_out, port_pin_one_out;
  logic        port_pin_zero_oe_n, port_pin_one_oe_n, out_clamp, offset_binary, gnd_adj_en;
  logic [31:0] seed = 32'h8d04;
  int          errors = 0, checks = 0, cyc = 0;
  pwr_state_io u_pwr_state_io (.ref_clk, .rstn, .addr, .wdata, .wr, .rd, .rdata,
    .async_zero_input, .load_update_strobe, .coding_select_pin, .port_pin_zero_in,
    .port_pin_one_in, .port_pin_zero_out, .port_pin_one_out, .port_pin_zero_oe_n,
    .port_pin_one_oe_n, .dac_code_a, .dac_code_b, .out_clamp, .offset_binary, .gnd_adj_en);
  port_pins_model u_port_pins_model (.oe0_n(port_pin_zero_oe_n), .oe1_n(port_pin_one_oe_n),
    .d0(port_pin_zero_out), .d1(port_pin_one_out), .ext, .p0(port_pin_zero_in),
    .p1(port_pin_one_in));
  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end
  // hang guard: the whole run needs about 750 cycles
  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 6000)
    begin
      errors = errors + 1;
      print_verdict();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // status after strap decode, before any write
  function automatic logic [15:0] exp_status(input logic c, z, l);
    return {11'h000, c, z & l, 1'b0, ~(z & l), 1'b1};
  endfunction : exp_status
  function automatic logic [1:0] exp_pins(input logic [1:0] dir, out, sw);
    return (dir & out) | (~dir & sw);
  endfunction : exp_pins
  task automatic chk(input logic [15:0] seen, exp);
    checks = checks + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge ref_clk);
    wr <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] q);
    @(posedge ref_clk);
    {rd, addr} <= {1'b1, a};
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    q = rdata;
  endtask : rd_reg
  task automatic print_verdict();
    if (errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  initial
  begin
    // every strap combination; straps settle before release
    for (int k = 0; k < 8; k++)
    begin
      @(posedge ref_clk);
      rstn <= 1'b0;
      {coding_select_pin, async_zero_input, load_update_strobe} <= k[2:0];
      repeat (20) @(posedge ref_clk);
      rstn <= 1'b1;
      wr_reg(4'h2, 16'h0001);
      chk(gnd_adj_en, 1'b0);
      v = 16'h0000;
      for (int i = 0; i < 80 && !v[0]; i++)
        rd_reg(4'h6, v);
      chk(v, exp_status(k[2], k[1], k[0]));
      chk(dac_code_a | dac_code_b, 16'h0000);
      chk(offset_binary, k[2]);
      chk(out_clamp, k[1] & k[0]);
      // first data write picks its channel by the coding strap: both release paths run
      seed = lfsr(seed);
      wr_reg({3'h0, ~k[2]}, seed[15:0]);
      chk(k[2] ? dac_code_a : dac_code_b, seed[15:0]);
      chk(k[2] ? dac_code_b : dac_code_a, 16'h0000);
      chk(out_clamp, 1'b0);
      wr_reg(4'h2, {15'h0000, seed[16]});
      chk(gnd_adj_en, seed[16]);
    end
    // random directions, drives and switch levels; sync needs 4 cycles
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      @(posedge ref_clk);
      ext <= seed[5:4];
      wr_reg(4'h3, {14'h0000, seed[1:0]});
      wr_reg(4'h4, {14'h0000, seed[3:2]});
      repeat (6) @(posedge ref_clk);
      rd_reg(4'h5, v);
      chk(v, {14'h0000, exp_pins(seed[1:0], seed[3:2], seed[5:4])});
      chk({port_pin_one_oe_n, port_pin_zero_oe_n}, {~seed[1:0]});
    end
    rd_reg(4'hf, v);
    chk(v, 16'h0000);
    print_verdict();
  end
endmodule : pwr_state_io_tb_top
bind pwr_state_io pwr_state_checker u_pwr_state_checker (.ref_clk, .rstn, .addr, .wdata,
  .wr, .rd, .rdata, .port_pin_zero_out, .port_pin_one_out, .port_pin_zero_oe_n,
  .port_pin_one_oe_n, .dac_code_a, .dac_code_b, .out_clamp, .offset_binary, .gnd_adj_en);
`default_nettype wire
